// ==== tb_test_board_control_registers.sv ====
// Purpose : self-checking bench of the test board control register bank
// Assumes : pulse length shortened to PLEN cycles to keep the run brief
// Notes   : random data from a fixed seed, with hand-picked corner values
`timescale 1ns/10ps
module tb_test_board_control_registers
	import tbc_pkg::*;
;
	localparam int          PLEN  = 8;
	localparam logic [1:0]  BASE  = 2'b10;
	localparam logic [15:0] MTYPE = 16'h3C3C;  // arbitrary value
	localparam logic [7:0]  FCODE = 8'h47;  // first experiment source, card type 3
	localparam logic [3:0]  ISS   = 4'h3;
	localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
	localparam logic [21:0] RA    = RAM_WIN_LO + 22'h00_0040;
	localparam logic [21:0] CA    = CARD_WIN_LO + 22'h00_0008;
	logic           mclk = 1'b0, sys_rst = 1'b1, p1 = 1'b0, p2 = 1'b0, rdy = 1'b0, ext = 1'b0;
	logic           pinit = 1'b0, pdone = 1'b0, pbusy = 1'b0;
	logic [7:6]     brcst = 2'b00;
	logic [7:0]     serial = 8'h00;
	logic [31:0]    rev1 = 32'h0000_0000, rev2 = 32'h0000_0000, mem_rdata = 32'h0000_0000;
	logic           as_n, ds_n, write_n, doe, dtack_n, dtack_oe, test_run, mem_req, mem_wr;
	logic           mem_wr_s;
	logic [5:0]     am;
	logic [23:2]    addr;
	logic [31:0]    din, dout, mem_wdata, mem_wd_s, rd;
	logic [4:0]     trim_a, trim_b;
	logic [3:0]     rst_p;
	logic [7:0]     irq_vec;
	logic [16:0]    user_sel;
	logic [14:0]    user_bus;
	logic [21:2]    mem_addr, mem_ad_s;
	tbc_prog_type   prog_ctrl;
	tbc_select_type prog_sel;
	int             seed = 26, err_total = 0, checks = 0, pn = 0;
	int             pc [4] = '{default: 0};
	int             pw [4] = '{default: 0};

	// 250 MHz board clock
	always #2 mclk = ~mclk;

	// ************************************************************
	// device, host model and memory port responder
	// ************************************************************
	tbc_regs #(.MODULE_TYPE(MTYPE), .ISSUE(ISS), .VERSION(8'h01), .FUNC_CODE(FCODE),
		.PULSE_LEN(PLEN), .MEM_LAT(MEM_LAT_CYC)) DUT (
		.MCLK(mclk), .SYS_RST(sys_rst), .BASE_SW(BASE), .BOARD_SERIAL(serial),
		.VME_AS_N(as_n), .VME_DS_N(ds_n), .VME_WRITE_N(write_n), .VME_AM(am),
		.VME_ADDR(addr), .VME_DIN(din), .VME_DOUT(dout), .VME_DOE(doe),
		.VME_DTACK_N(dtack_n), .VME_DTACK_OE(dtack_oe), .BRCST(brcst),
		.PROC1_CFG_DONE(p1), .PROC2_CFG_DONE(p2), .TIMING_RX_READY(rdy),
		.CLK_SRC_EXT(ext), .PROC1_REV(rev1), .PROC2_REV(rev2), .PROG_INIT(pinit),
		.PROG_DONE(pdone), .PROG_BUSY(pbusy), .TEST_RUN(test_run), .TRIM_A(trim_a),
		.TRIM_B(trim_b), .RESET_PULSES(rst_p), .PROG_CTRL(prog_ctrl), .PROG_SELECT(prog_sel),
		.IRQ_VECTOR(irq_vec), .USER_SEL(user_sel), .USER_BUS(user_bus), .MEM_REQ(mem_req),
		.MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata)
	);
	tbc_host host (
		.mclk(mclk), .as_n(as_n), .ds_n(ds_n), .write_n(write_n), .am(am), .addr(addr),
		.din(din), .dout(dout), .dtack_n(dtack_n), .dtack_oe(dtack_oe)
	);

	// read data carries its own address, so a word from the wrong place shows up
	always @(posedge mclk) begin
		if (mem_req === 1'b1) begin
			mem_rdata <= {12'hA5C, mem_addr};
			mem_wr_s  <= mem_wr;
			mem_ad_s  <= mem_addr;
			mem_wd_s  <= mem_wdata;
		end
	end

	// pulse widths kept per bit; pn counts every pulse seen on any bit
	always @(negedge mclk) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_p[i] === 1'b1)
				pc[i]++;
			else if (pc[i] != 0) begin
				pw[i] = pc[i];
				pn++;
				pc[i] = 0;
			end
		end
	end

	// expected status word for given run and remote flags
	function automatic logic [31:0] stat_exp(input logic run, input logic remote);
		stat_exp = {27'h000_0000, rdy, remote, run, p2, p1};
	endfunction : stat_exp

	// expected one-hot select: eeproms in the upper nibble, chip selects below
	function automatic logic [7:0] sel_exp(input logic [3:0] s);
		sel_exp = 8'h00;
		if (s >= 4'h1 && s <= SEL_EE_LAST)
			sel_exp = 8'h08 << s;
		else if (s > SEL_EE_LAST && s <= SEL_CS_LAST)
			sel_exp = 8'h01 << (s - 4'h5);
	endfunction : sel_exp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		checks++;
		if (((got ^ exp) & msk) !== 32'h0000_0000) begin
			err_total++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// register access with either answered modifier
	task automatic acc(input logic wr, input logic [21:0] ofs, input logic [31:0] wd);
		logic       ack;
		logic [5:0] m;
		m = ($random(seed) & 1) ? AM_A24_USER : AM_A24_SUPER;
		host.xfer(wr, {BASE, ofs}, wd, m, rd, ack);
		chk_bit(ack, 1'b1);
	endtask : acc

	task automatic rdc(input logic [21:0] ofs, input logic [31:0] exp, input logic [31:0] msk);
		acc(1'b0, ofs, 32'h0000_0000);
		chk(rd, exp, msk);
	endtask : rdc

	task automatic finish_test;
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// whole run is well under a thousand cycles; this bound only catches a hung handshake
	initial begin
		#100000;
		err_total++;
		finish_test();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		logic [31:0] v;
		logic [31:0] r;
		logic        ack;
		int          k;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		v = $random(seed);
		r = $random(seed);
		serial <= v[7:0];
		{p1, p2, rdy} <= v[10:8];
		rev1 <= {r[31:16], MTYPE};
		rev2 <= r;
		acc(1'b1, OFS_STATUS, ALL);
		acc(1'b1, OFS_IDENTITY, ALL);
		rdc(OFS_CONTROL, RST_ZERO, ALL);
		rdc(OFS_IDENTITY, {4'h0, ISS, v[7:0], MTYPE}, 32'h0FFF_FFFF);
		rdc(OFS_STATUS, stat_exp(1'b0, 1'b0), ALL);
		rdc(OFS_CTRL_REV, {8'h01, FCODE, MTYPE}, ALL);
		rdc(OFS_PROC1_REV, rev1, ALL);
		rdc(OFS_PROC2_REV, rev2, ALL);
		rdc(22'h00_0030, RST_ZERO, ALL);
		host.xfer(1'b0, {BASE, OFS_CONTROL}, 32'h0000_0000, 6'h09, rd, ack);
		chk_bit(ack, 1'b0);
		host.xfer(1'b1, {~BASE, OFS_CONTROL}, 32'h0000_0001, AM_A24_USER, rd, ack);
		chk_bit(ack, 1'b0);
		// run request on its own, then broadcast start, hold and stop
		acc(1'b1, OFS_CONTROL, 32'h0000_0001);
		repeat (3) @(posedge mclk);
		chk_bit(test_run, 1'b1);
		rdc(OFS_STATUS, stat_exp(1'b1, 1'b0), ALL);
		acc(1'b1, OFS_CONTROL, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk_bit(test_run, 1'b0);
		for (k = 0; k < 3; k++) begin
			brcst <= (k == 0) ? BRC_START : ((k == 1) ? 2'b10 : BRC_STOP);
			repeat (6) @(posedge mclk);
			chk_bit(test_run, k < 2);
			rdc(OFS_STATUS, stat_exp(k < 2, k < 2), 32'hFFFF_FFFB);
		end
		// a second reset in mid-run clears the run request
		acc(1'b1, OFS_CONTROL, 32'h0000_0001);
		sys_rst <= 1'b1;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk_bit(test_run, 1'b0);
		rdc(OFS_CONTROL, RST_ZERO, ALL);
		for (k = 0; k < 3; k++) begin
			v = (k == 0) ? 32'h0000_03FF : ($random(seed) & 32'h0000_03FF);
			ext <= 1'b1;
			acc(1'b1, OFS_TRIM, v);
			repeat (3) @(posedge mclk);
			chk(32'({trim_b, trim_a}), v, ALL);
			rdc(OFS_TRIM, v, 32'h0000_03FF);
			ext <= 1'b0;
			repeat (3) @(posedge mclk);
			chk(32'({trim_b, trim_a}), RST_ZERO, ALL);
		end
		// a zero write first must not fire anything, then one pulse per bit
		for (k = 0; k < 4; k++) begin
			r = pn;
			acc(1'b1, OFS_PULSE, 32'h0000_0000);
			acc(1'b1, OFS_PULSE, 32'h0000_0001 << k);
			repeat (PLEN + 4) @(posedge mclk);
			chk(pw[k], PLEN, ALL);
			chk(pn, r + 1, ALL);
			rdc(OFS_PULSE, RST_ZERO, ALL);
		end
		// every select code, including one past the last
		for (k = 0; k < 10; k++) begin
			r = $random(seed);
			v = {12'h000, k[3:0], 5'h00, r[10:0]};
			{pbusy, pdone, pinit} <= r[31:29];
			acc(1'b1, OFS_PROGRAM, v);
			repeat (3) @(posedge mclk);
			chk(32'(prog_sel), 32'(sel_exp(k[3:0])), ALL);
			chk(32'(prog_ctrl), 32'({~v[10], ~v[9], v[8:0]}), ALL);
			rdc(OFS_PROGRAM, v | {18'h0_0000, pbusy, pdone, pinit, 11'h000}, 32'h000F_3FFF);
		end
		v = $random(seed);
		acc(1'b1, OFS_IRQ_VEC, v);
		acc(1'b1, OFS_USER_SEL, v);
		acc(1'b1, OFS_USER_BUS, v);
		chk(32'(irq_vec), v, 32'h0000_00FF);
		chk(32'(user_sel), v, 32'h0001_FFFF);
		chk(32'(user_bus), v, 32'h0000_7FFF);
		rdc(OFS_IRQ_VEC, v, 32'h0000_00FF);
		rdc(OFS_USER_SEL, v, 32'h0001_FFFF);
		acc(1'b1, RA, v);
		chk(32'({mem_wr_s, mem_ad_s}), {11'h000, 1'b1, RA[21:2]}, ALL);
		chk(mem_wd_s, v, ALL);
		rdc(CA, {12'hA5C, CA[21:2]}, ALL);
		finish_test();
	end
endmodule : tb_test_board_control_registers

// ==== tbc_host.sv ====
// Purpose : vme a24 master model that drives the register bank
// Assumes : whole 32-bit cycles, one at a time
// Notes   : released address, modifier and data lines show the inverse of their last value, never a stale copy
`timescale 1ns/10ps
module tbc_host (
	input  wire logic        mclk,
	output logic             as_n,
	output logic             ds_n,
	output logic             write_n,
	output logic [5:0]       am,
	output logic [23:2]      addr,
	output logic [31:0]      din,
	input  wire logic [31:0] dout,
	input  wire logic        dtack_n,
	input  wire logic        dtack_oe
);
	// bus idle at time zero
	initial begin
		{as_n, ds_n, write_n, am, addr, din} = {3'b111, 60'h000_0000_0000_0000};
	end

	// one cycle: request held until dtack is seen low at a falling edge or 24 falling edges pass, released at the next rising edge
	task automatic xfer(
		input  logic        wr,
		input  logic [23:0] a,
		input  logic [31:0] wd,
		input  logic [5:0]  m,
		output logic [31:0] rd,
		output logic        ack
	);
		int n;
		ack = 1'b0;
		rd  = 32'h0000_0000;
		@(posedge mclk);
		{as_n, ds_n, write_n, am, addr, din} <= {2'b00, ~wr, m, a[23:2], wd};
		for (n = 0; n < 24 && !ack; n++) begin
			@(negedge mclk);
			if (dtack_oe === 1'b1 && dtack_n === 1'b0) begin
				ack = 1'b1;
				rd  = dout;
			end
		end
		@(posedge mclk);
		{as_n, ds_n, write_n, am, addr, din} <= {3'b111, ~m, ~a[23:2], ~wd};
		// no new cycle until the slave has let go of dtack, plus one idle edge
		for (n = 0; n < 24 && dtack_oe !== 1'b0; n++)
			@(negedge mclk);
		@(posedge mclk);
	endtask : xfer
endmodule : tbc_host

// ==== tbc_pkg.sv ====
// Purpose : constants and types shared by the test board control register bank
// Assumes : 32-bit registers, one aligned long-word each, in a 4 Mbyte A24 space
// Notes   : all addresses are byte addresses within the module space
package tbc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [21:0] OFS_IDENTITY  = 22'h00_0000;
	localparam logic [21:0] OFS_CONTROL   = 22'h00_0004;
	localparam logic [21:0] OFS_STATUS    = 22'h00_0008;
	localparam logic [21:0] OFS_TRIM      = 22'h00_000C;
	localparam logic [21:0] OFS_PULSE     = 22'h00_0010;
	localparam logic [21:0] OFS_PROGRAM   = 22'h00_0014;
	localparam logic [21:0] OFS_CTRL_REV  = 22'h00_0018;
	localparam logic [21:0] OFS_PROC1_REV = 22'h00_001C;
	localparam logic [21:0] OFS_PROC2_REV = 22'h00_0020;
	localparam logic [21:0] OFS_IRQ_VEC   = 22'h00_0024;
	localparam logic [21:0] OFS_USER_SEL  = 22'h00_0028;
	localparam logic [21:0] OFS_USER_BUS  = 22'h00_002C;
	// buffer windows: card memory then board dual-port ram
	localparam logic [21:0] CARD_WIN_LO   = 22'h08_0000;
	localparam logic [21:0] CARD_WIN_HI   = 22'h1F_FFFF;
	localparam logic [21:0] RAM_WIN_LO    = 22'h20_0000;

	// ************************************************************
	// address modifiers answered
	// ************************************************************
	localparam logic [5:0] AM_A24_USER  = 6'h39;
	localparam logic [5:0] AM_A24_SUPER = 6'h3D;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int ID_SERIAL_LSB  = 16;
	localparam int ID_ISSUE_LSB   = 24;
	localparam int TRIM_B_LSB     = 5;
	localparam int PRG_CCLK_BIT   = 8;
	localparam int PRG_PROG_BIT   = 9;
	localparam int PRG_WRITE_BIT  = 10;
	localparam int PRG_INIT_BIT   = 11;
	localparam int PRG_DONE_BIT   = 12;
	localparam int PRG_BUSY_BIT   = 13;
	localparam int PRG_SEL_LSB    = 16;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [7:0]  FUNC_VME = 8'h80;
	localparam logic [3:0]  SEL_NONE = 4'h0;
	localparam logic [3:0]  SEL_EE_LAST = 4'h4;
	localparam logic [3:0]  SEL_CS_LAST = 4'h8;
	localparam logic [1:0]  BRC_START = 2'b01;
	localparam logic [1:0]  BRC_STOP  = 2'b00;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int PULSE_TIME_NS  = 200;
	localparam int PULSE_CYC      = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int MEM_LAT_CYC    = 4;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		TBC_IDLE = 2'b00,
		TBC_MEM  = 2'b01,
		TBC_ACK  = 2'b10
	} tbc_state_type;

	typedef struct packed {
		logic       write_n;
		logic       prog_n;
		logic       cclk;
		logic [7:0] data;
	} tbc_prog_type;

	typedef struct packed {
		logic [3:0] eeprom_sel;
		logic [3:0] fpga_cs;
	} tbc_select_type;

endpackage : tbc_pkg

// ==== tbc_regs.sv ====
// Purpose : control/status register bank of the test board controller, vme a24 slave
// Assumes : vme strobes already synchronous to MCLK, single 32-bit data strobe
// Notes   : buffer windows are forwarded to an external memory port with fixed latency
//
// How it works
// RQ1: identity holds type, serial, issue
// RQ2: control word clears to zero on reset
// RQ3: control bit 0 requests run
// RQ4: run is request OR remote start
// RQ5: broadcast 01 starts, 00 stops
// RQ6: status is read-only, writes ignored
// RQ7: status bits show config, run, remote, ready
// RQ8: remote flag follows broadcast start/stop
// RQ9: trim bits set two 1 ns phases
// RQ10: trim applies only on external clock
// RQ11: pulse bit 0 resets processing fpgas
// RQ12: pulse bit 1 resets timing receiver
// RQ13: pulse bits 2,3 reset cards
// RQ14: pulse bits read zero, zero ignored
// RQ15: programming word drives fpga configuration
// RQ16: select field decodes eeproms and chip selects
// RQ17: controller revision: version, function, id
// RQ18: processor revisions share layout and id
// RQ19: function codes follow fixed encoding
// RQ20: interrupt vector register is reserved; the code stores bits 7:0 and drives them on IRQ_VECTOR
// RQ21: user select and bussed lines driven
// RQ22: buffer windows reach memories
// RQ23: only modifiers 39 and 3D answered
// RQ24: every mapped access gets acknowledge
// RQ25: host sequences programming bits correctly
// RQ26: pulse width counted from next cycle
// RQ27: broadcast start synchronised before use
`timescale 1ns/10ps
module tbc_regs
	import tbc_pkg::*;
#(
	parameter logic [15:0] MODULE_TYPE = 16'h5A5A,  // arbitrary value
	parameter logic [3:0]  ISSUE       = 4'h1,
	parameter logic [7:0]  VERSION     = 8'h01,
	parameter logic [7:0]  FUNC_CODE   = FUNC_VME,
	parameter int          PULSE_LEN   = PULSE_CYC,
	parameter int          MEM_LAT     = MEM_LAT_CYC
) (
	input  wire logic           MCLK,
	input  wire logic           SYS_RST,
	input  wire logic [1:0]     BASE_SW,
	input  wire logic [7:0]     BOARD_SERIAL,
	input  wire logic           VME_AS_N,
	input  wire logic           VME_DS_N,
	input  wire logic           VME_WRITE_N,
	input  wire logic [5:0]     VME_AM,
	input  wire logic [23:2]    VME_ADDR,
	input  wire logic [31:0]    VME_DIN,
	output logic [31:0]         VME_DOUT,
	output logic                VME_DOE,
	output logic                VME_DTACK_N,
	output logic                VME_DTACK_OE,
	input  wire logic [7:6]     BRCST,
	input  wire logic           PROC1_CFG_DONE,
	input  wire logic           PROC2_CFG_DONE,
	input  wire logic           TIMING_RX_READY,
	input  wire logic           CLK_SRC_EXT,
	input  wire logic [31:0]    PROC1_REV,
	input  wire logic [31:0]    PROC2_REV,
	input  wire logic           PROG_INIT,
	input  wire logic           PROG_DONE,
	input  wire logic           PROG_BUSY,
	output logic                TEST_RUN,
	output logic [4:0]          TRIM_A,
	output logic [4:0]          TRIM_B,
	output logic [3:0]          RESET_PULSES,
	output tbc_prog_type        PROG_CTRL,
	output tbc_select_type      PROG_SELECT,
	output logic [7:0]          IRQ_VECTOR,
	output logic [16:0]         USER_SEL,
	output logic [14:0]         USER_BUS,
	output logic                MEM_REQ,
	output logic                MEM_WR,
	output logic [21:2]         MEM_ADDR,
	output logic [31:0]         MEM_WDATA,
	input  wire logic [31:0]    MEM_RDATA
);

	// ************************************************************
	// state
	// ************************************************************
	tbc_state_type state_r;
	logic          run_req_r;
	logic [1:0]    brc_meta_r;
	logic [1:0]    brc_sync_r;
	logic          remote_run_r;
	logic [9:0]    trim_r;
	logic [18:0]   prog_r;
	logic [3:0]    sel_r;
	logic [3:0]    mem_cnt_r;
	logic [5:0]    pulse_cnt_r [4];
	logic [31:0]   rdata_nxt;
	logic          in_win_nxt;
	logic [21:0]   ofs;
	logic          strobe;

	assign ofs    = {VME_ADDR[21:2], 2'b00};
	// a new cycle starts only from idle with both strobes low
	assign strobe = (state_r == TBC_IDLE) && !VME_AS_N && !VME_DS_N
		&& ((VME_AM == AM_A24_USER) || (VME_AM == AM_A24_SUPER))  // RQ23
		&& (VME_ADDR[23:22] == BASE_SW);

	// ************************************************************
	// address decode and read mux
	// ************************************************************
	always_comb begin
		in_win_nxt = (ofs >= CARD_WIN_LO);  // RQ22
		rdata_nxt  = RST_ZERO;
		unique case (ofs)
			OFS_IDENTITY:  rdata_nxt = {4'h0, ISSUE, BOARD_SERIAL, MODULE_TYPE};  // RQ1
			OFS_CONTROL:   rdata_nxt = {31'h0000_0000, run_req_r};
			OFS_STATUS:    rdata_nxt = {27'h000_0000, TIMING_RX_READY, remote_run_r,
				TEST_RUN, PROC2_CFG_DONE, PROC1_CFG_DONE};  // RQ7
			OFS_TRIM:      rdata_nxt = {22'h00_0000, trim_r};
			OFS_PULSE:     rdata_nxt = RST_ZERO;  // RQ14
			OFS_PROGRAM:   rdata_nxt = {12'h000, sel_r, 2'b00, PROG_BUSY, PROG_DONE,
				PROG_INIT, prog_r[10:0]};
			OFS_CTRL_REV:  rdata_nxt = {VERSION, FUNC_CODE, MODULE_TYPE};  // RQ17 RQ19
			OFS_PROC1_REV: rdata_nxt = PROC1_REV;  // RQ18
			OFS_PROC2_REV: rdata_nxt = PROC2_REV;  // RQ18
			OFS_IRQ_VEC:   rdata_nxt = {24'h00_0000, IRQ_VECTOR};
			OFS_USER_SEL:  rdata_nxt = {15'h0000, USER_SEL};
			OFS_USER_BUS:  rdata_nxt = {17'h0_0000, USER_BUS};
			default:       rdata_nxt = RST_ZERO;  // unused holes read zero but still answer
		endcase
	end

	// ************************************************************
	// bus handshake: dtack held until the master lifts its strobe
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			state_r      <= TBC_IDLE;
			mem_cnt_r    <= 4'h0;
			VME_DTACK_N  <= 1'b1;
			VME_DTACK_OE <= 1'b0;
			VME_DOE      <= 1'b0;
			VME_DOUT     <= RST_ZERO;
		end else begin
			unique case (state_r)
				TBC_IDLE: if (strobe) begin
					VME_DOUT <= rdata_nxt;
					if (in_win_nxt) begin
						state_r   <= TBC_MEM;
						mem_cnt_r <= 4'(MEM_LAT);
					end else begin
						state_r      <= TBC_ACK;  // RQ24
						VME_DTACK_N  <= 1'b0;
						VME_DTACK_OE <= 1'b1;
						VME_DOE      <= VME_WRITE_N;
					end
				end
				TBC_MEM: begin
					mem_cnt_r <= mem_cnt_r - 4'h1;
					if (mem_cnt_r == 4'h1) begin
						state_r      <= TBC_ACK;  // RQ24
						VME_DOUT     <= MEM_RDATA;  // RQ22
						VME_DTACK_N  <= 1'b0;
						VME_DTACK_OE <= 1'b1;
						VME_DOE      <= VME_WRITE_N;
					end
				end
				TBC_ACK: if (VME_DS_N) begin
					state_r      <= TBC_IDLE;
					VME_DTACK_N  <= 1'b1;
					VME_DTACK_OE <= 1'b0;
					VME_DOE      <= 1'b0;
				end
				default: state_r <= TBC_IDLE;
			endcase
		end
	end

	// ************************************************************
	// memory window port: one-cycle request at the start of a cycle
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			MEM_REQ   <= 1'b0;
			MEM_WR    <= 1'b0;
			MEM_ADDR  <= 20'h0_0000;
			MEM_WDATA <= RST_ZERO;
		end else begin
			MEM_REQ <= strobe && in_win_nxt;  // RQ22
			if (strobe && in_win_nxt) begin
				MEM_WR    <= !VME_WRITE_N;
				MEM_ADDR  <= VME_ADDR[21:2];
				MEM_WDATA <= VME_DIN;
			end
		end
	end

	// ************************************************************
	// run request and remote start
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			run_req_r <= 1'b0;  // RQ2
		end else if (strobe && !VME_WRITE_N && ofs == OFS_CONTROL) begin
			run_req_r <= VME_DIN[0];  // RQ3
		end
	end

	// two-stage sync; only the second stage is decoded
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			brc_meta_r   <= 2'b00;
			brc_sync_r   <= 2'b00;
			remote_run_r <= 1'b0;
		end else begin
			brc_meta_r <= BRCST;  // RQ27
			brc_sync_r <= brc_meta_r;
			if (brc_sync_r == BRC_START) begin
				remote_run_r <= 1'b1;  // RQ5 RQ8
			end else if (brc_sync_r == BRC_STOP) begin
				remote_run_r <= 1'b0;  // RQ5 RQ8
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			TEST_RUN <= 1'b0;
		end else begin
			TEST_RUN <= run_req_r | remote_run_r;  // RQ4
		end
	end

	// ************************************************************
	// clock phase trim; zero steps while the timing receiver clocks us
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			trim_r <= 10'h000;
			TRIM_A <= 5'h00;
			TRIM_B <= 5'h00;
		end else begin
			if (strobe && !VME_WRITE_N && ofs == OFS_TRIM) begin
				trim_r <= VME_DIN[9:0];  // RQ9
			end
			TRIM_A <= CLK_SRC_EXT ? trim_r[TRIM_B_LSB-1:0] : 5'h00;  // RQ10
			TRIM_B <= CLK_SRC_EXT ? trim_r[9:TRIM_B_LSB] : 5'h00;  // RQ10
		end
	end

	// ************************************************************
	// reset pulses: a retrigger during a pulse is ignored
	// ************************************************************
	for (genvar i = 0; i < 4; i++) begin : g_pulse
		always_ff @(posedge MCLK) begin
			if (SYS_RST) begin
				pulse_cnt_r[i]  <= 6'h00;
				RESET_PULSES[i] <= 1'b0;
			end else if (strobe && !VME_WRITE_N && ofs == OFS_PULSE && VME_DIN[i]
				&& pulse_cnt_r[i] == 6'h00) begin
				pulse_cnt_r[i]  <= 6'(PULSE_LEN);  // RQ11 RQ12 RQ13 RQ26
				RESET_PULSES[i] <= 1'b1;
			end else if (pulse_cnt_r[i] != 6'h00) begin
				pulse_cnt_r[i]  <= pulse_cnt_r[i] - 6'h01;
				RESET_PULSES[i] <= (pulse_cnt_r[i] != 6'h01);
			end
		end
	end

	// ************************************************************
	// programming word and device select decode
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			prog_r      <= 19'h0_0000;
			sel_r       <= SEL_NONE;
			PROG_CTRL   <= '{write_n: 1'b1, prog_n: 1'b1, cclk: 1'b0, data: 8'h00};
			PROG_SELECT <= '{eeprom_sel: 4'h0, fpga_cs: 4'h0};
		end else begin
			if (strobe && !VME_WRITE_N && ofs == OFS_PROGRAM) begin
				prog_r <= VME_DIN[18:0];  // RQ15
				sel_r  <= VME_DIN[PRG_SEL_LSB+3:PRG_SEL_LSB];
			end
			PROG_CTRL.write_n <= !prog_r[PRG_WRITE_BIT];  // RQ15
			PROG_CTRL.prog_n  <= !prog_r[PRG_PROG_BIT];
			PROG_CTRL.cclk    <= prog_r[PRG_CCLK_BIT];
			PROG_CTRL.data    <= prog_r[7:0];
			for (int k = 0; k < 4; k++) begin
				PROG_SELECT.eeprom_sel[k] <= (sel_r == 4'(k + 1));  // RQ16
				PROG_SELECT.fpga_cs[k]    <= (sel_r == 4'(k + 5));  // RQ16
			end
		end
	end

	// ************************************************************
	// interrupt vector and user lines: plain storage
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			IRQ_VECTOR <= 8'h00;
			USER_SEL   <= 17'h0_0000;
			USER_BUS   <= 15'h0000;
		end else if (strobe && !VME_WRITE_N) begin
			if (ofs == OFS_IRQ_VEC) begin
				IRQ_VECTOR <= VME_DIN[7:0];  // RQ20
			end
			if (ofs == OFS_USER_SEL) begin
				USER_SEL <= VME_DIN[16:0];  // RQ21
			end
			if (ofs == OFS_USER_BUS) begin
				USER_BUS <= VME_DIN[14:0];  // RQ21
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	logic wr_pulse;
	assign wr_pulse = strobe && !VME_WRITE_N && ofs == OFS_PULSE;

	sequence s_ack_rise;
		$fell(VME_DTACK_N);
	endsequence

	sequence s_ack_hold;
		!VME_DTACK_N [*1] ##1 (!VME_DTACK_N || VME_DS_N);
	endsequence

	property p_only_known_am;
		@(posedge MCLK) disable iff (SYS_RST)
		s_ack_rise |-> $past(state_r) != TBC_IDLE || $past(VME_AM) == AM_A24_USER
			|| $past(VME_AM) == AM_A24_SUPER;
	endproperty
	a_only_known_am: assert property (p_only_known_am)  // RQ23
		else $error("dtack for an unanswered modifier");

	property p_reg_ack;
		@(posedge MCLK) disable iff (SYS_RST)
		strobe && !in_win_nxt |=> s_ack_rise;
	endproperty
	a_reg_ack: assert property (p_reg_ack)  // RQ24
		else $error("register access not acknowledged next cycle");

	property p_mem_ack;
		@(posedge MCLK) disable iff (SYS_RST)
		strobe && in_win_nxt |-> ##[1:20] !VME_DTACK_N;
	endproperty
	a_mem_ack: assert property (p_mem_ack)  // RQ22
		else $error("window access not acknowledged");

	property p_run_or;
		@(posedge MCLK) disable iff (SYS_RST)
		##1 TEST_RUN == ($past(run_req_r) | $past(remote_run_r));
	endproperty
	a_run_or: assert property (p_run_or)  // RQ4
		else $error("run output is not request or remote start");

	property p_remote_start;
		@(posedge MCLK) disable iff (SYS_RST)
		BRCST == BRC_START [*3] |=> remote_run_r;
	endproperty
	a_remote_start: assert property (p_remote_start)  // RQ5
		else $error("broadcast start not seen");

	property p_remote_stop;
		@(posedge MCLK) disable iff (SYS_RST)
		BRCST == BRC_STOP [*3] |=> !remote_run_r;
	endproperty
	a_remote_stop: assert property (p_remote_stop)  // RQ8
		else $error("broadcast stop not seen");

	property p_pulse_width;
		@(posedge MCLK) disable iff (SYS_RST)
		wr_pulse && VME_DIN[0] && !RESET_PULSES[0] |=> RESET_PULSES[0] [*8];
	endproperty
	a_pulse_width: assert property (p_pulse_width)  // RQ11
		else $error("reset pulse too short");

	property p_pulse_ends;
		@(posedge MCLK) disable iff (SYS_RST)
		$rose(RESET_PULSES[1]) |-> ##PULSE_LEN !RESET_PULSES[1];
	endproperty
	a_pulse_ends: assert property (p_pulse_ends)  // RQ12
		else $error("reset pulse does not end after 200 ns");

	property p_trim_gate;
		@(posedge MCLK) disable iff (SYS_RST)
		!$past(CLK_SRC_EXT) |-> TRIM_A == 5'h00 && TRIM_B == 5'h00;
	endproperty
	a_trim_gate: assert property (p_trim_gate)  // RQ10
		else $error("trim applied on receiver clock");

	property p_sel_onehot;
		@(posedge MCLK) disable iff (SYS_RST)
		$countones({PROG_SELECT.eeprom_sel, PROG_SELECT.fpga_cs}) <= 1;
	endproperty
	a_sel_onehot: assert property (p_sel_onehot)  // RQ16
		else $error("more than one device selected");

	property p_ack_hold;
		@(posedge MCLK) disable iff (SYS_RST)
		s_ack_rise |-> s_ack_hold;
	endproperty
	a_ack_hold: assert property (p_ack_hold)  // RQ24
		else $error("dtack dropped before strobe release");

endmodule : tbc_regs
